// file: rtl/twrs_slave.v
// two-wire register slave: serial framing, register pointer, readback and write stream
// assumes serial lines arrive asynchronously; status inputs come from logic on clk
//
// Operation
// - data rising while clock high ends transfer
// - data falling while clock high starts transfer
// - bytes shift most significant bit first
// - nine clocks per byte, ninth acknowledges
// - write: acknowledge address match and data bytes
// - read: acknowledge address, release after each byte
// - unlimited byte count until stop
// - first byte is write slave address
// - write: address, register index, then data bytes
// - read begins with read address, open-drain data
// - pointer advances after each byte sent
// - status bit four shows oscillator unlocked
// - vsync missing flags, bit five mirrors bit zero
// - status bit one shows inset burst present
// - second status bit seven shows colour killer
// - second status bits four, three: service flags
// - second status bits one, zero: data pending
// - even sliced word high then low byte
// - odd sliced word high then low byte
`include "twrs_regs.vh"

module twrs_slave #(
	parameter BUF_WIDTH = 16
) (
	input wire clk,
	input wire rst_n,
	input wire serial_clock_in,
	input wire serial_data_line_in,
	output wire serial_data_line_out,
	output wire serial_data_line_oe,
	input wire xtal_loop_unlocked,
	input wire main_vsync_missing,
	input wire inset_burst_present,
	input wire inset_vsync_missing,
	input wire colour_killer_active,
	input wire even_field_service_flag,
	input wire odd_field_service_flag,
	input wire even_field_read_pending,
	input wire odd_field_read_pending,
	input wire [15:0] even_field_sliced_word,
	input wire [15:0] odd_field_sliced_word,
	output wire cfg_wr_valid,
	input wire cfg_wr_ready,
	output wire [7:0] cfg_wr_addr,
	output wire [7:0] cfg_wr_data,
	output wire transfer_active
);

	// ---------------------------------------------------------------
	// protocol states, one-hot
	// ---------------------------------------------------------------
	localparam [7:0] S_IDLE = 8'h01;
	localparam [7:0] S_ADDR = 8'h02;
	localparam [7:0] S_AACK = 8'h04;
	localparam [7:0] S_REG = 8'h08;
	localparam [7:0] S_WDAT = 8'h10;
	localparam [7:0] S_DACK = 8'h20;
	localparam [7:0] S_RDAT = 8'h40;
	localparam [7:0] S_MACK = 8'h80;

	reg [1:0] scl_sync_q;
	reg [1:0] sda_sync_q;
	reg scl_prev_q;
	reg sda_prev_q;
	reg [7:0] state_q;
	reg [7:0] shift_q;
	reg [3:0] cnt_q;
	reg [7:0] ptr_q;
	reg oe_q;
	reg read_q;
	reg mack_q;
	reg active_q;
	reg [7:0] cfg_mem [0:`TWRS_CFG_COUNT-1];
	reg [7:0] rd_byte;
	wire scl_s;
	wire sda_s;
	wire scl_rise;
	wire scl_fall;
	wire start_cond;
	wire stop_cond;
	wire byte_done;
	wire wr_byte_done;
	wire buf_in_ready;
	wire buf_push;
	wire mem_we;
	wire [BUF_WIDTH-1:0] buf_out;
	integer i;

	// ---------------------------------------------------------------
	// pin synchronisers and edge detection
	// ---------------------------------------------------------------
	// two flops per line; only the second stage feeds any logic
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync_q <= 2'b11;
			sda_sync_q <= 2'b11;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], serial_clock_in};
			sda_sync_q <= {sda_sync_q[0], serial_data_line_in};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end

	assign scl_s = scl_sync_q[1];
	assign sda_s = sda_sync_q[1];
	assign scl_rise = scl_s & ~scl_prev_q;
	assign scl_fall = ~scl_s & scl_prev_q;
	// a data edge with the clock steady high is framing, never a bit
	assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// eighth bit is in, this falling edge opens the acknowledge slot
	assign byte_done = scl_fall & (cnt_q == `TWRS_BITS_PER_BYTE);
	assign wr_byte_done = byte_done & (state_q == S_WDAT);

	// ---------------------------------------------------------------
	// readback multiplexer
	// ---------------------------------------------------------------
	// status is sampled at the moment the byte is loaded for shifting
	always @* begin
		rd_byte = 8'h00;
		case (ptr_q)
			`TWRS_LOCK_AND_SYNC_STATUS: begin
				rd_byte[`TWRS_LS_UNLOCK_BIT] = xtal_loop_unlocked;
				rd_byte[`TWRS_LS_MAIN_VSYNC_BIT] = main_vsync_missing;
				rd_byte[`TWRS_LS_BURST_BIT] = inset_burst_present;
				rd_byte[`TWRS_LS_INSET_VSYNC_BIT] = inset_vsync_missing;
			end
			`TWRS_SLICER_AND_KILLER_STATUS: begin
				rd_byte[`TWRS_SK_KILLER_BIT] = colour_killer_active;
				rd_byte[`TWRS_SK_INSET_VSYNC_BIT] = inset_vsync_missing;
				rd_byte[`TWRS_SK_EVEN_SERVICE_BIT] = even_field_service_flag;
				rd_byte[`TWRS_SK_ODD_SERVICE_BIT] = odd_field_service_flag;
				rd_byte[`TWRS_SK_EVEN_PENDING_BIT] = even_field_read_pending;
				rd_byte[`TWRS_SK_ODD_PENDING_BIT] = odd_field_read_pending;
			end
			`TWRS_EVEN_SLICE_HIGH_BYTE: begin
				rd_byte = even_field_sliced_word[15:8];
			end
			`TWRS_EVEN_SLICE_LOW_BYTE: begin
				rd_byte = even_field_sliced_word[7:0];
			end
			`TWRS_ODD_SLICE_HIGH_BYTE: begin
				rd_byte = odd_field_sliced_word[15:8];
			end
			`TWRS_ODD_SLICE_LOW_BYTE: begin
				rd_byte = odd_field_sliced_word[7:0];
			end
			default: begin
				// writable range reads back its shadow; beyond the map reads zero
				if (ptr_q <= `TWRS_CFG_LAST) begin
					rd_byte = cfg_mem[ptr_q[4:0]];
				end
			end
		endcase
	end

	// ---------------------------------------------------------------
	// write path: shadow registers and outgoing stream
	// ---------------------------------------------------------------
	// a stalled consumer makes the byte go unacknowledged rather than lost silently
	assign buf_push = wr_byte_done & buf_in_ready;
	// read-only addresses take no store, but still stream and advance
	assign mem_we = buf_push & (ptr_q <= `TWRS_CFG_LAST);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < `TWRS_CFG_COUNT; i = i + 1) begin
				cfg_mem[i] <= `TWRS_CFG_RESET;
			end
		end else if (mem_we) begin
			cfg_mem[ptr_q[4:0]] <= shift_q;
		end
	end

	twrs_buf2 #(
		.WIDTH(BUF_WIDTH)
	) u_wr_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(buf_push),
		.in_ready(buf_in_ready),
		.in_data({ptr_q, shift_q}),
		.out_valid(cfg_wr_valid),
		.out_ready(cfg_wr_ready),
		.out_data(buf_out)
	);

	assign cfg_wr_addr = buf_out[15:8];
	assign cfg_wr_data = buf_out[7:0];

	// ---------------------------------------------------------------
	// protocol engine
	// ---------------------------------------------------------------
	// all line changes happen on the falling clock so the master sees them settled
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			shift_q <= 8'h00;
			cnt_q <= 4'd0;
			ptr_q <= 8'h00;
			oe_q <= 1'b0;
			read_q <= 1'b0;
			mack_q <= 1'b0;
			active_q <= 1'b0;
		end else if (stop_cond) begin
			// bus is free; pointer is kept for a following read
			state_q <= S_IDLE;
			oe_q <= 1'b0;
			cnt_q <= 4'd0;
			active_q <= 1'b0;
		end else if (start_cond) begin
			// also a repeated start from any state
			state_q <= S_ADDR;
			oe_q <= 1'b0;
			cnt_q <= 4'd0;
			active_q <= 1'b1;
		end else begin
			case (state_q)
				S_IDLE: begin
					oe_q <= 1'b0;
				end
				S_ADDR: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'd1;
					end else if (byte_done) begin
						if (shift_q == `TWRS_WR_SLAVE_ADDR) begin
							oe_q <= 1'b1;
							read_q <= 1'b0;
							state_q <= S_AACK;
						end else if (shift_q == `TWRS_RD_SLAVE_ADDR) begin
							oe_q <= 1'b1;
							read_q <= 1'b1;
							state_q <= S_AACK;
						end else begin
							// another device is addressed: sit out until the next start
							state_q <= S_IDLE;
						end
					end
				end
				S_AACK: begin
					if (scl_fall) begin
						cnt_q <= 4'd0;
						if (read_q) begin
							// first read byte leaves as its first bit goes out
							shift_q <= {rd_byte[6:0], 1'b0};
							oe_q <= ~rd_byte[7];
							cnt_q <= 4'd1;
							ptr_q <= ptr_q + 8'h01;
							state_q <= S_RDAT;
						end else begin
							oe_q <= 1'b0;
							state_q <= S_REG;
						end
					end
				end
				S_REG: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'd1;
					end else if (byte_done) begin
						ptr_q <= shift_q;
						oe_q <= 1'b1;
						state_q <= S_DACK;
					end
				end
				S_WDAT: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_s};
						cnt_q <= cnt_q + 4'd1;
					end else if (byte_done) begin
						if (buf_in_ready) begin
							ptr_q <= ptr_q + 8'h01;
							oe_q <= 1'b1;
							state_q <= S_DACK;
						end else begin
							// stream full: leave the slot high so the master sees a refusal
							state_q <= S_IDLE;
						end
					end
				end
				S_DACK: begin
					if (scl_fall) begin
						oe_q <= 1'b0;
						cnt_q <= 4'd0;
						state_q <= S_WDAT;
					end
				end
				S_RDAT: begin
					if (byte_done) begin
						// let go so the master can answer in the ninth slot
						oe_q <= 1'b0;
						state_q <= S_MACK;
					end else if (scl_fall) begin
						oe_q <= ~shift_q[7];
						shift_q <= {shift_q[6:0], 1'b0};
						cnt_q <= cnt_q + 4'd1;
					end
				end
				S_MACK: begin
					if (scl_rise) begin
						mack_q <= ~sda_s;
					end else if (scl_fall) begin
						if (mack_q) begin
							shift_q <= {rd_byte[6:0], 1'b0};
							oe_q <= ~rd_byte[7];
							cnt_q <= 4'd1;
							ptr_q <= ptr_q + 8'h01;
							state_q <= S_RDAT;
						end else begin
							// no answer from the master: read is over, wait for stop
							oe_q <= 1'b0;
							state_q <= S_IDLE;
						end
					end
				end
				default: begin
					state_q <= S_IDLE;
					oe_q <= 1'b0;
				end
			endcase
		end
	end

	// open-drain: the pin is only ever pulled low, released means high impedance
	assign serial_data_line_out = 1'b0;
	assign serial_data_line_oe = oe_q;
	assign transfer_active = active_q;

endmodule // twrs_slave

// file: common/twrs_regs.vh
// register map, bus addresses and field positions of the two-wire register slave
// assumes it is included by bare name from the design files; definitions only
`ifndef TWRS_REGS_VH
`define TWRS_REGS_VH

// ---------------------------------------------------------------
// slave addresses seen on the serial data line
// ---------------------------------------------------------------
`define TWRS_WR_SLAVE_ADDR 8'h24
`define TWRS_RD_SLAVE_ADDR 8'h25

// ---------------------------------------------------------------
// internal register map
// ---------------------------------------------------------------
`define TWRS_CFG_FIRST 8'h00
`define TWRS_CFG_LAST 8'h1E
`define TWRS_CFG_COUNT 31
`define TWRS_CFG_RESET 8'h00
`define TWRS_LOCK_AND_SYNC_STATUS 8'h1F
`define TWRS_SLICER_AND_KILLER_STATUS 8'h20
`define TWRS_EVEN_SLICE_HIGH_BYTE 8'h21
`define TWRS_EVEN_SLICE_LOW_BYTE 8'h22
`define TWRS_ODD_SLICE_HIGH_BYTE 8'h23
`define TWRS_ODD_SLICE_LOW_BYTE 8'h24

// ---------------------------------------------------------------
// lock_and_sync_status fields
// ---------------------------------------------------------------
`define TWRS_LS_UNLOCK_BIT 4
`define TWRS_LS_MAIN_VSYNC_BIT 2
`define TWRS_LS_BURST_BIT 1
`define TWRS_LS_INSET_VSYNC_BIT 0

// ---------------------------------------------------------------
// slicer_and_killer_status fields
// ---------------------------------------------------------------
`define TWRS_SK_KILLER_BIT 7
`define TWRS_SK_INSET_VSYNC_BIT 5
`define TWRS_SK_EVEN_SERVICE_BIT 4
`define TWRS_SK_ODD_SERVICE_BIT 3
`define TWRS_SK_EVEN_PENDING_BIT 1
`define TWRS_SK_ODD_PENDING_BIT 0

// ---------------------------------------------------------------
// byte framing
// ---------------------------------------------------------------
`define TWRS_BITS_PER_BYTE 4'd8

`endif

// file: rtl/twrs_buf2.v
// two-entry valid/ready buffer for completed register writes
// assumes both sides run on clk; in_ready low means the source must hold off
module twrs_buf2 #(
	parameter WIDTH = 16
) (
	input wire clk,
	input wire rst_n,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] slot0_q;
	reg [WIDTH-1:0] slot1_q;
	reg wr_sel_q;
	reg rd_sel_q;
	reg [1:0] fill_q;
	wire push;
	wire pop;

	// honest full and empty from the fill count
	assign in_ready = (fill_q != 2'd2);
	assign out_valid = (fill_q != 2'd0);
	assign out_data = rd_sel_q ? slot1_q : slot0_q;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// ---------------------------------------------------------------
	// storage and pointers
	// ---------------------------------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slot0_q <= {WIDTH{1'b0}};
			slot1_q <= {WIDTH{1'b0}};
			wr_sel_q <= 1'b0;
			rd_sel_q <= 1'b0;
			fill_q <= 2'd0;
		end else begin
			if (push) begin
				if (wr_sel_q) begin
					slot1_q <= in_data;
				end else begin
					slot0_q <= in_data;
				end
				wr_sel_q <= ~wr_sel_q;
			end
			if (pop) begin
				rd_sel_q <= ~rd_sel_q;
			end
			// simultaneous push and pop leave the count alone
			if (push & ~pop) begin
				fill_q <= fill_q + 2'd1;
			end else if (pop & ~push) begin
				fill_q <= fill_q - 2'd1;
			end
		end
	end

endmodule // twrs_buf2

// file: tb/twrs_chk.sv
// port assertions for the two-wire register slave
// assumes binding to twrs_slave, one clock domain, rst_n active low
module twrs_chk (
	input wire clk,
	input wire rst_n,
	input wire serial_clock_in,
	input wire serial_data_line_in,
	input wire serial_data_line_out,
	input wire serial_data_line_oe,
	input wire cfg_wr_valid,
	input wire cfg_wr_ready,
	input wire [7:0] cfg_wr_addr,
	input wire [7:0] cfg_wr_data,
	input wire transfer_active
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// data edge while the serial clock stays high
	sequence s_start;
		serial_clock_in && serial_data_line_in ##1 serial_clock_in && !serial_data_line_in;
	endsequence
	sequence s_stop;
		serial_clock_in && !serial_data_line_in ##1 serial_clock_in && serial_data_line_in;
	endsequence
	a_start_opens: assert property (s_start |-> ##[1:6] transfer_active)
		else $error("start did not open a transfer");
	a_stop_closes: assert property (s_stop |-> ##[1:6] !transfer_active)
		else $error("stop did not close the transfer");
	a_idle_released: assert property (!transfer_active |-> !serial_data_line_oe)
		else $error("line pulled while bus free");
	// the slave may only move the line while the clock is low
	a_oe_clock_low: assert property ($changed(serial_data_line_oe) |-> !serial_clock_in)
		else $error("line moved while clock high");
	a_oe_bounded: assert property ($rose(serial_data_line_oe) |-> ##[1:130] !serial_data_line_oe)
		else $error("line held low too long");
	a_push_acks: assert property ($rose(cfg_wr_valid) |-> serial_data_line_oe && transfer_active)
		else $error("byte stored without acknowledge");
	// a stalled word must not move or vanish
	a_stream_hold: assert property (cfg_wr_valid && !cfg_wr_ready |=>
		cfg_wr_valid && $stable(cfg_wr_addr) && $stable(cfg_wr_data))
		else $error("stream word changed while stalled");
	a_open_drain: assert property (serial_data_line_out == 1'b0)
		else $error("line driven high");
endmodule // twrs_chk

// file: tb/twrs_master.sv
// serial bus master model driving the slave's clock and data wire
// assumes the bench resolves the wire with a pull-up; 12 clk per serial period
module twrs_master (
	input wire logic clk,
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	// clock idles high, line released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// release while clock low, then fall while clock high
	task automatic start();
		sda_low <= 1'b0;
		tick(3);
		scl <= 1'b1;
		tick(6);
		sda_low <= 1'b1;
		tick(6);
		scl <= 1'b0;
		tick(3);
	endtask
	// rise while clock high, clock then stands still
	task automatic stop();
		sda_low <= 1'b1;
		tick(3);
		scl <= 1'b1;
		tick(6);
		sda_low <= 1'b0;
		tick(6);
	endtask
	// eight bits then the ninth slot; mack pulls the ninth low
	task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			sda_low <= (i == 0) ? mack : ~tx[i-1]; // mid low phase only
			tick(3);
			scl <= 1'b1;
			tick(3);
			if (i > 0)
				rx[i-1] = sda;
			else
				ack = ~sda;
			tick(3);
			scl <= 1'b0;
			tick(3);
		end
	endtask
endmodule // twrs_master

// file: tb/testbench.sv
// self-checking bench for twrs_slave against a queue and array model
// assumes twrs_master as bus master and twrs_chk bound below
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic scl, m_low, sda, oe, out, vld, act, hold = 1'b0;
	logic cfg_wr_ready = 1'b0;
	logic [7:0] wa, wd;
	logic [8:0] st = '0;
	logic [15:0] ew = '0;
	logic [15:0] ow = '0;
	logic [7:0] mem [256];
	logic [15:0] wq [$];
	int miscompares = 0;
	int total_checks = 0;
	always #2 clk = ~clk;
	// pull-up wire: low if either party pulls
	assign sda = ~(m_low | (oe & ~out));
	twrs_master m (.clk(clk), .scl(scl), .sda_low(m_low), .sda(sda));
	twrs_slave dut (.clk(clk), .rst_n(rst_n), .serial_clock_in(scl), .serial_data_line_in(sda),
		.serial_data_line_out(out), .serial_data_line_oe(oe), .xtal_loop_unlocked(st[8]),
		.main_vsync_missing(st[7]), .inset_burst_present(st[6]), .inset_vsync_missing(st[5]),
		.colour_killer_active(st[4]), .even_field_service_flag(st[3]), .odd_field_service_flag(st[2]),
		.even_field_read_pending(st[1]), .odd_field_read_pending(st[0]), .even_field_sliced_word(ew),
		.odd_field_sliced_word(ow), .cfg_wr_valid(vld), .cfg_wr_ready(cfg_wr_ready), .cfg_wr_addr(wa),
		.cfg_wr_data(wd), .transfer_active(act));
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// random consumer stalls; hold forces a full buffer
	always @(posedge clk) begin
		cfg_wr_ready <= hold ? 1'b0 : 1'($urandom_range(1));
		if (vld === 1'b1 && cfg_wr_ready === 1'b1) begin
			check(wa, wq[0][15:8], "stream index");
			check(wd, wq[0][7:0], "stream byte");
			void'(wq.pop_front());
		end
	end
	function automatic logic [7:0] expect_rd(input logic [7:0] a);
		case (a)
			8'h1f: return {3'b000, st[8], 1'b0, st[7:5]};
			8'h20: return {st[4], 1'b0, st[5], st[3:2], 1'b0, st[1:0]};
			8'h21: return ew[15:8];
			8'h22: return ew[7:0];
			8'h23: return ow[15:8];
			8'h24: return ow[7:0];
			default: return (a < 8'h1f) ? mem[a] : 8'h00;
		endcase
	endfunction
	// bytes past lim are expected refused by a full buffer
	task automatic wr(input logic [7:0] idx, input int n, input int lim);
		logic [7:0] rx, d;
		logic ack;
		m.start();
		m.xfer(8'h24, 1'b0, rx, ack);
		check(8'(ack), 8'h01, "write address ack");
		m.xfer(idx, 1'b0, rx, ack);
		check(8'(ack), 8'h01, "index ack");
		for (int k = 0; k < n; k++) begin
			d = 8'($urandom);
			// queue before sending: the word can leave the buffer inside the ack slot
			if (k < lim) begin
				if (idx < 8'h1f)
					mem[idx] = d; // read-only places keep their value
				wq.push_back({idx, d});
				idx++;
			end
			m.xfer(d, 1'b0, rx, ack);
			check(8'(ack), 8'(k < lim), "data ack");
		end
		m.stop();
	endtask
	task automatic rd(input logic [7:0] idx, input int n);
		logic [7:0] rx;
		logic ack;
		wr(idx, 0, 0); // pointer set, stop, new start
		m.start();
		m.xfer(8'h25, 1'b0, rx, ack);
		check(8'(ack), 8'h01, "read address ack");
		for (int k = 0; k < n; k++) begin
			m.xfer(8'hff, k < n - 1, rx, ack);
			check(rx, expect_rd(idx), "read byte");
			idx++;
		end
		m.stop();
	endtask
	task automatic wait_drain();
		int t;
		for (t = 0; t < 300 && wq.size() != 0; t++)
			@(posedge clk);
		if (wq.size() != 0) begin
			miscompares++;
			$display("unexpected at %0t: stream not drained", $time);
			finish_test();
		end
	endtask
	// watchdog against a hung run
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		$display("unexpected at %0t: run too long", $time);
		finish_test();
	end
	initial begin
		logic [7:0] rx;
		logic ack;
		void'($urandom(96002));
		foreach (mem[i])
			mem[i] = 8'h00;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		check({5'b00000, oe, vld, act}, 8'h00, "reset outputs");
		$display("test reset done");
		wr(8'h1d, 4, 4); // burst across config and status
		wait_drain();
		$display("test burst write done");
		for (int r = 0; r < 3; r++) begin
			st <= 9'($urandom);
			ew <= 16'($urandom);
			ow <= 16'($urandom);
			rd(8'h1d, 9);
		end
		$display("test readback done");
		hold <= 1'b1;
		wr(8'h00, 3, 2); // third byte refused
		hold <= 1'b0;
		wait_drain();
		rd(8'h00, 3);
		$display("test buffer full done");
		m.start();
		m.xfer(8'h26, 1'b0, rx, ack);
		check(8'(ack), 8'h00, "foreign address ack");
		m.stop();
		$display("test foreign address done");
		finish_test();
	end
endmodule // testbench

bind twrs_slave twrs_chk u_chk (.clk(clk), .rst_n(rst_n), .serial_clock_in(serial_clock_in),
	.serial_data_line_in(serial_data_line_in), .serial_data_line_out(serial_data_line_out),
	.serial_data_line_oe(serial_data_line_oe), .cfg_wr_valid(cfg_wr_valid), .cfg_wr_ready(cfg_wr_ready),
	.cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data), .transfer_active(transfer_active));
